// >>> design/dual_sar_adc_conversion_sequencer.sv
// Conversion sequencer for a dual 18-bit successive-approximation converter
//
// Behaviour
// [RL1] Convert rising edge starts a conversion and holds both channels together.
// [RL2] Controller drops convert low at least 50ns before the 19th clock edge.
// [RL3] Controller should keep convert high about 81ns at 192kHz rate.
// [RL4] Only conversion clock rising edges act; duty cycle does not matter.
// [RL5] Controller captures serial data on conversion clock rising edges.
// [RL6] Exactly 19 clock edges per conversion; later edges ignored until next convert.
// [RL7] From the 19th edge both sample-and-holds track until next convert edge.
// [RL8] Controller should stop the clock after the 19th edge.
// [RL9] No clock edge in guard after convert; first edge decides the MSB.
// [RL10] Any idle gap between conversions is accepted, no maximum.
// [RL11] Convert rates from 48kHz to 222kHz, nominal 192kHz, are supported.
// [RL12] Results are 18-bit two's complement.
// [RL13] Bits resolve MSB to LSB, one per clock, kept unless overshooting.
// [RL14] Both channels test the same bit each interval from one sequencer.
// [RL15] Each serial bit appears one clock after its decision is latched.
// [RL16] Two serial streams, one per channel, 18 bits MSB first.
// [RL17] Clock lockout holds from the 19th edge until next convert edge.
module dual_sar_adc_conversion_sequencer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic convert_cmd,
  input wire logic conversion_clock_in,
  input wire sar_seq_pkg::dual_bit_s comp_keep,
  output sar_seq_pkg::dual_word_s dac_code,
  output logic sample_hold,
  output logic serial_left,
  output logic serial_right,
  output sar_seq_pkg::dual_word_s result,
  output logic result_valid,
  output logic clock_lockout,
  output logic busy
);

  logic conv_sync1;
  logic conv_sync2;
  logic conv_prev;
  logic cclk_sync1;
  logic cclk_sync2;
  logic cclk_prev;
  sar_seq_pkg::seq_state_e state;
  sar_seq_pkg::seq_state_e next_state;
  logic [4:0] edge_cnt;
  logic [4:0] next_edge_cnt;
  logic [17:0] code [2];
  logic [17:0] res [2];
  logic ser [2];
  logic last_dec [2];
  logic keep [2];

  // Both pins come from outside; two flops before any edge detection
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      conv_sync1 <= 1'b0;
      conv_sync2 <= 1'b0;
      conv_prev <= 1'b0;
    end else begin
      conv_sync1 <= convert_cmd;
      conv_sync2 <= conv_sync1;
      conv_prev <= conv_sync2;
    end
  end

  // [RL11] Any level held two mclk cycles is seen, far above the fastest rate
  // Reset to the idle low level, so no false clock edge follows reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cclk_sync1 <= 1'b0;
      cclk_sync2 <= 1'b0;
      cclk_prev <= 1'b0;
    end else begin
      cclk_sync1 <= conversion_clock_in;
      cclk_sync2 <= cclk_sync1;
      cclk_prev <= cclk_sync2;
    end
  end

  wire conv_rise = conv_sync2 & ~conv_prev;
  // [RL4] Rising edges only
  wire cclk_rise = cclk_sync2 & ~cclk_prev;
  // [RL6] Edges count only while converting; a convert edge wins a tie
  wire conv_edge = cclk_rise & (state == sar_seq_pkg::ST_CONVERT) & ~conv_rise;
  wire take_bit = conv_edge & (edge_cnt <= sar_seq_pkg::LAST_DECISION_EDGE);
  wire shift_out = conv_edge & (edge_cnt != sar_seq_pkg::EDGE_CNT_RESET);
  wire track_edge = conv_edge & (edge_cnt == sar_seq_pkg::TRACK_EDGE);
  wire [4:0] bit_pos = sar_seq_pkg::MSB_POS - edge_cnt;

  // Comparator verdicts come from same-clock logic, so they are not synchronised
  assign keep[0] = comp_keep.left;
  assign keep[1] = comp_keep.right;

  // Guard and convert pulse timing are the controller's duty and are not checked
  // [RL1] Convert edge restarts regardless of state
  // [RL10] No timeout on the idle gap
  always_comb begin
    next_state = state;
    next_edge_cnt = edge_cnt;
    if (conv_rise) begin
      next_state = sar_seq_pkg::ST_CONVERT;
      next_edge_cnt = sar_seq_pkg::EDGE_CNT_RESET;
    end else if (track_edge) begin
      next_state = sar_seq_pkg::ST_LOCKOUT;
    end else if (conv_edge) begin
      next_edge_cnt = edge_cnt + 5'h01;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= sar_seq_pkg::ST_TRACK;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      edge_cnt <= sar_seq_pkg::EDGE_CNT_RESET;
    end else begin
      edge_cnt <= next_edge_cnt;
    end
  end

  // [RL7] Hold from convert edge, track from the 19th edge
  wire next_sample_hold = (next_state == sar_seq_pkg::ST_CONVERT);
  // [RL17] Lockout stays until the next convert edge
  wire next_clock_lockout = (next_state == sar_seq_pkg::ST_LOCKOUT);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sample_hold <= 1'b0;
    end else begin
      sample_hold <= next_sample_hold;
    end
  end

  // Busy mirrors the hold flop but keeps its own flop, so both leave a register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= next_sample_hold;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clock_lockout <= 1'b0;
    end else begin
      clock_lockout <= next_clock_lockout;
    end
  end

  // One-cycle strobe in the cycle the new result first stands
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      result_valid <= 1'b0;
    end else begin
      result_valid <= track_edge;
    end
  end

  // [RL14] One shared count steers both channel ranks
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    wire is_msb = (bit_pos == sar_seq_pkg::MSB_POS);
    // [RL12] Offset-binary search, MSB inverted gives two's complement
    wire dec_bit = keep[ch] ^ is_msb;
    wire [17:0] final_word = {~code[ch][17], code[ch][16:0]};

    // [RL9] MSB trial is set up at the convert edge; first clock decides it
    // [RL13] Drop the trial bit on overshoot, then trial the next one down
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        code[ch] <= sar_seq_pkg::CODE_RESET;
      end else if (conv_rise) begin
        code[ch] <= sar_seq_pkg::MSB_TRIAL;
      end else if (take_bit) begin
        code[ch][bit_pos] <= keep[ch];
        if (bit_pos != 5'h00) begin
          code[ch][bit_pos - 5'h01] <= 1'b1;
        end
      end
    end

    // A convert edge never meets take_bit, so the decision needs no clear
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        last_dec[ch] <= 1'b0;
      end else if (take_bit) begin
        last_dec[ch] <= dec_bit;
      end
    end

    // [RL15] Serial bit lags its decision by one conversion clock
    // [RL16] MSB first on each channel's own stream
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        ser[ch] <= 1'b0;
      end else if (conv_rise) begin
        ser[ch] <= 1'b0;
      end else if (shift_out) begin
        ser[ch] <= last_dec[ch];
      end
    end

    // Result holds through lockout and any idle gap
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        res[ch] <= sar_seq_pkg::CODE_RESET;
      end else if (track_edge) begin
        res[ch] <= final_word;
      end
    end
  end

  assign dac_code.left = code[0];
  assign dac_code.right = code[1];
  assign result.left = res[0];
  assign result.right = res[1];
  assign serial_left = ser[0];
  assign serial_right = ser[1];

endmodule : dual_sar_adc_conversion_sequencer

// >>> design/sar_seq_pkg.sv
// Shared constants and carriers for the dual SAR conversion sequencer
package sar_seq_pkg;

  localparam int unsigned RESULT_BITS = 18;
  localparam int unsigned CONV_EDGES = 19;
  localparam logic [4:0] EDGE_CNT_RESET = 5'h00;
  localparam logic [4:0] LAST_DECISION_EDGE = 5'h11;
  localparam logic [4:0] TRACK_EDGE = 5'h12;
  localparam logic [4:0] MSB_POS = 5'h11;
  localparam logic [17:0] MSB_TRIAL = 18'h2_0000;
  localparam logic [17:0] CODE_RESET = 18'h0_0000;

  // Convert rates the sequencer is sized for, in Hz
  localparam int unsigned RATE_MIN_HZ = 48000;
  localparam int unsigned RATE_NOM_HZ = 192000;
  localparam int unsigned RATE_MAX_HZ = 222000;
  localparam int unsigned MCLK_HZ = 250000000;
  // Longest convert period, in mclk cycles; the sequencer itself has no timeout
  localparam int unsigned CONV_PERIOD_MAX_CYC = MCLK_HZ / RATE_MIN_HZ;

  typedef enum logic [1:0] {
    ST_TRACK = 2'b00,
    ST_CONVERT = 2'b01,
    ST_LOCKOUT = 2'b10
  } seq_state_e;

  typedef struct packed {
    logic left;
    logic right;
  } dual_bit_s;

  typedef struct packed {
    logic [17:0] left;
    logic [17:0] right;
  } dual_word_s;

endpackage : sar_seq_pkg

// >>> verif/host_ctrl_model.sv
// Controller and comparator model facing the sequencer
module host_ctrl_model (
  input logic mclk,
  input sar_seq_pkg::dual_word_s dac_code,
  input logic serial_left,
  input logic serial_right,
  output logic convert_cmd = 1'h0,
  output logic conversion_clock_in = 1'h0,
  output sar_seq_pkg::dual_bit_s comp_keep
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [17:0] tl = '0, tr = '0, sl, sr;
  // Ideal comparator, so the final code must equal the held input
  assign comp_keep = {dac_code.left <= tl, dac_code.right <= tr};
  task automatic frame(input int n, input bit cv);
    if (cv) begin
      convert_cmd <= 1'h1;
      repeat (20) @(posedge mclk);
      convert_cmd <= 1'h0;
      repeat (20) @(posedge mclk);
    end
    repeat (n) begin
      // Blocking, so the bench sees the last bit as soon as the task returns
      {sl, sr} = {sl[16:0], serial_left, sr[16:0], serial_right};
      conversion_clock_in <= 1'h1;
      repeat (20) @(posedge mclk);
      conversion_clock_in <= 1'h0;
      repeat (20) @(posedge mclk);
    end
    {sl, sr} = {sl[16:0], serial_left, sr[16:0], serial_right};
  endtask : frame
endmodule : host_ctrl_model

// >>> verif/sar_seq_checker.sv
// Port assertions for the dual SAR sequencer
module sar_seq_checker (
  input logic mclk,
  input logic rst,
  input logic convert_cmd,
  input sar_seq_pkg::dual_word_s dac_code,
  input logic sample_hold,
  input logic serial_left,
  input sar_seq_pkg::dual_word_s result,
  input logic result_valid,
  input logic clock_lockout
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence lock_held;
    clock_lockout ##1 clock_lockout;
  endsequence
  chk_conv_hold: assert property ($rose(convert_cmd) |-> ##[1:4] sample_hold)
    else $error("no hold");
  chk_valid_once: assert property (result_valid |=> !result_valid)
    else $error("long valid");
  chk_track_end: assert property (result_valid |-> clock_lockout && !sample_hold)
    else $error("no track");
  chk_lock_until: assert property (clock_lockout && !convert_cmd |=> clock_lockout)
    else $error("lock lost");
  chk_lock_frozen: assert property (lock_held |-> $stable(dac_code))
    else $error("moved in lock");
  chk_result_held: assert property (!result_valid |-> $stable(result))
    else $error("result moved");
  chk_msb_trial: assert property ($rose(sample_hold) |->
    dac_code == {2{sar_seq_pkg::MSB_TRIAL}}) else $error("bad trial");
  chk_lsb_out: assert property (result_valid |-> serial_left == result.left[0])
    else $error("bad lsb");
endmodule : sar_seq_checker
bind dual_sar_adc_conversion_sequencer sar_seq_checker chk_u (.*);

// >>> verif/test_dual_sar_adc_conversion_sequencer.sv
// Self-checking bench for the dual SAR conversion sequencer
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
  $display("MISMATCH %0t %h %h", $time, a, b); end end
module test_dual_sar_adc_conversion_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst = 1, convert_cmd, conversion_clock_in, serial_left, serial_right;
  logic sample_hold, result_valid, clock_lockout, busy;
  sar_seq_pkg::dual_bit_s comp_keep;
  sar_seq_pkg::dual_word_s dac_code, result;
  int mismatches = 0, checks_done = 0, cyc = 0;
  // Held inputs, then expected words: only the sign bit flips
  logic [17:0] rows [4][4] = '{'{18'h3_FFFF, 18'h0_0000, 18'h1_FFFF, 18'h2_0000},
    '{18'h2_0000, 18'h1_FFFF, 18'h0_0000, 18'h3_FFFF},
    '{18'h0_0001, 18'h2_AAAA, 18'h2_0001, 18'h0_AAAA},
    '{18'h1_5555, 18'h3_FFFE, 18'h3_5555, 18'h1_FFFE}};
  dual_sar_adc_conversion_sequencer dut_u (.*);
  host_ctrl_model ctl (.*);
  initial forever #2 mclk = ~mclk;
  always @(posedge mclk) if (++cyc > 20000) begin
    mismatches++;
    tally_and_finish();
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    `CHK({busy, sample_hold, clock_lockout, result_valid, serial_left, serial_right}, 6'h00)
    `CHK({dac_code, result}, 72'h0)
    foreach (rows[i]) begin
      ctl.tl <= rows[i][0];
      ctl.tr <= rows[i][1];
      ctl.frame(19, 1);
      `CHK(result, {rows[i][2], rows[i][3]})
      `CHK({ctl.sl, ctl.sr}, {rows[i][2], rows[i][3]})
      `CHK({busy, clock_lockout}, 2'h1)
    end
    ctl.tl <= 18'h0_0000;
    ctl.frame(6, 0);
    `CHK(result, {18'h3_5555, 18'h1_FFFE})
    `CHK({clock_lockout, sample_hold}, 2'h2)
    repeat (2000) @(posedge mclk);
    ctl.frame(10, 1);
    `CHK({busy, sample_hold, clock_lockout}, 3'h6)
    `CHK(dac_code, {18'h0_0080, 18'h3_FF80})
    ctl.tl <= 18'h1_2345;
    ctl.frame(19, 1);
    `CHK(result, {18'h3_2345, 18'h1_FFFE})
    `CHK({ctl.sl, ctl.sr}, {18'h3_2345, 18'h1_FFFE})
    rst <= 1'h1;
    @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    `CHK({busy, sample_hold, clock_lockout, result_valid, dac_code, result}, 76'h0)
    ctl.tr <= 18'h0_0001;
    ctl.frame(19, 1);
    `CHK(result, {18'h3_2345, 18'h2_0001})
    tally_and_finish();
  end
endmodule : test_dual_sar_adc_conversion_sequencer
